// *** hdl/pmx_mode_dec.sv ***
// Purpose: decode mode-select straps into an operating mode
// Assumes: straps are synchronised before they arrive here
// Notes:   codes not recognised count as a mode with no external bus
`timescale 1ns/1ps
module pmx_mode_dec (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // synchronised mode-select straps
  input  wire logic [2:0]   md,
  // decoded mode, registered
  output pmx_pkg::pmx_mode_t mode_r
);
  // mode is re-read every cycle; straps are static on a real board
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= pmx_pkg::PMX_SINGLE_CHIP;
    end else if (md == pmx_pkg::PMX_MD_SINGLE) begin
      mode_r <= pmx_pkg::PMX_SINGLE_CHIP;
    end else if (md <= pmx_pkg::PMX_MD_EXT_HI) begin
      mode_r <= pmx_pkg::PMX_EXT_BUS;
    end else begin
      mode_r <= pmx_pkg::PMX_OTHER;
    end
  end
endmodule // pmx_mode_dec

// *** hdl/pmx_pkg.sv ***
// Purpose: shared constants for the port-3 pin function selector
// Assumes: eight port-3 pins, one clock, no register bus
// Notes:   bit positions name the pin that carries each alternate function
package pmx_pkg;
  localparam int PMX_NPINS     = 8;    // port-3 width
  localparam int PMX_BIT_LATCH = 0;    // address latch strobe pin
  localparam int PMX_BIT_READ  = 1;    // read strobe pin
  localparam int PMX_BIT_LSTB  = 2;    // low/byte store strobe pin
  localparam int PMX_BIT_HSTB  = 3;    // high byte store strobe pin
  localparam int PMX_BIT_HREQ  = 4;    // hold request input pin
  localparam int PMX_BIT_HGNT  = 5;    // hold grant output pin
  localparam int PMX_BIT_RDY   = 6;    // ready input pin
  localparam int PMX_BIT_BCLK  = 7;    // bus clock output pin
  localparam int PMX_CMP_LO    = 4;    // first compare-wave pin
  localparam logic [7:0] PMX_RST_ZERO = 8'h00; // reset value of port registers
  localparam logic       PMX_RST_HI   = 1'h1;  // reset level of bus_ready, which idles high
  // operating modes decoded from the three mode-select pins
  typedef enum logic [1:0] {PMX_SINGLE_CHIP, PMX_EXT_BUS, PMX_OTHER} pmx_mode_t;
  localparam logic [2:0] PMX_MD_SINGLE = 3'h3; // single-chip mode code
  localparam logic [2:0] PMX_MD_EXT_LO = 3'h0; // external bus mode codes 0..2
  localparam logic [2:0] PMX_MD_EXT_HI = 3'h2;
endpackage

// *** hdl/pmx_port3.sv ***
// Overview of operation
// - bit0 is GPIO, or latch strobe on bus
// - bit1 is GPIO, or read strobe on bus
// - bit2 GPIO in single-chip or strobe off
// - bit2 low strobe when bus and enabled
// - low strobe covers low byte or byte
// - bit3 GPIO single-chip, 8-bit, or disabled
// - bit3 high strobe: bus, 16-bit, enabled
// - bit4 hold request input with hold on
// - bit5 hold grant output with hold on
// - bits 4,5 GPIO without bus or hold, compare off
// - bit6 ready input with ready enabled
// - bit7 bus clock when bus and enabled
// - per-bit pull-up selection register
// - bits 0,1 capture, bit2 irq10 input
// - bits 4..7 carry compare waves 4..7
//
// Purpose: port-3 pin function selector for the external bus controls
// Assumes: bus controller, timers and port registers sit on mclk
// Notes:   all outputs registered, so pins lag their sources one cycle
`timescale 1ns/1ps
module pmx_port3 #(
  parameter int NPINS = pmx_pkg::PMX_NPINS
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // mode-select straps from the board
  input  wire logic             mode_select_0,
  input  wire logic             mode_select_1,
  input  wire logic             mode_select_2,
  // configuration bits
  input  wire logic             bus_16bit,      // high: 16-bit bus width
  input  wire logic             low_strobe_en,  // low/byte store strobe enable
  input  wire logic             high_strobe_en, // high byte store strobe enable
  input  wire logic             hold_en,        // hold function enable
  input  wire logic             ready_en,       // external ready enable
  input  wire logic             bclk_out_en,    // bus clock output enable
  input  wire logic             compare_en,     // compare waves on bits 4..7
  // port register writes
  input  wire logic             pdr_we,         // load output data
  input  wire logic [NPINS-1:0] pdr_wdata,
  input  wire logic             ddr_we,         // load direction (1 = out)
  input  wire logic [NPINS-1:0] ddr_wdata,
  input  wire logic             pucr_we,        // load pull-up selection
  input  wire logic [NPINS-1:0] pucr_wdata,
  // bus controller side
  input  wire logic             bus_latch_n,
  input  wire logic             bus_read_n,
  input  wire logic             low_byte_store_strobe,
  input  wire logic             high_byte_store_strobe,
  input  wire logic             bus_hold_grant,
  input  wire logic             bus_clk,
  output logic                  bus_hold_request, // synchronised request
  output logic                  bus_ready,        // synchronised ready
  // timer side
  input  wire logic [3:0]       compare_wave,     // channels 4..7
  output logic                  capture_channel_4,
  output logic                  capture_channel_5,
  output logic                  ext_irq10_pin,
  // status
  output logic                  ext_bus_mode,
  output logic [NPINS-1:0]      pin_data,         // synchronised pin levels
  // port-3 pins
  input  wire logic [NPINS-1:0] port3_in,
  output logic      [NPINS-1:0] port3_out,
  output logic      [NPINS-1:0] port3_oe,
  output logic      [NPINS-1:0] port3_pullup
);
  logic [NPINS-1:0]     pdr_r;        // gpio output data
  logic [NPINS-1:0]     ddr_r;        // gpio direction
  logic [NPINS-1:0]     pucr_r;       // pull-up selection
  logic [NPINS-1:0]     pin_s;        // synchronised pin levels
  logic [2:0]           md_s;         // synchronised straps
  pmx_pkg::pmx_mode_t   mode_r;       // decoded mode
  logic                 ext;          // external bus enabled
  logic [NPINS-1:0]     alt_sel;      // pin owned by an alternate function
  logic [NPINS-1:0]     alt_oe;       // alternate function drives the pin
  logic [NPINS-1:0]     alt_out;      // alternate function level
  logic [NPINS-1:0]     out_nxt;
  logic [NPINS-1:0]     oe_nxt;
  logic [NPINS-1:0]     pu_nxt;

  // pins and straps are asynchronous, so each passes two flops
  pmx_sync #(.W(NPINS)) u_pin_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    (port3_in),
    .q    (pin_s)
  );

  pmx_sync #(.W(3)) u_md_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({mode_select_2, mode_select_1, mode_select_0}),
    .q    (md_s)
  );

  // board supplies the mode; we only decode it
  pmx_mode_dec u_mode (
    .mclk   (mclk),
    .nrst   (nrst),
    .md     (md_s),
    .mode_r (mode_r)
  );

  assign ext = (mode_r == pmx_pkg::PMX_EXT_BUS);

  // gpio data register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pdr_r <= pmx_pkg::PMX_RST_ZERO;
    end else if (pdr_we) begin
      pdr_r <= pdr_wdata;
    end
  end

  // gpio direction register; reset leaves every pin an input
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ddr_r <= pmx_pkg::PMX_RST_ZERO;
    end else if (ddr_we) begin
      ddr_r <= ddr_wdata;
    end
  end

  // pull-up selection register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pucr_r <= pmx_pkg::PMX_RST_ZERO;
    end else if (pucr_we) begin
      pucr_r <= pucr_wdata;
    end
  end

  // ownership and drive of each pin by the external bus functions
  always_comb begin
    alt_sel = '0;
    alt_oe  = '0;
    alt_out = '0;
    alt_sel[pmx_pkg::PMX_BIT_LATCH] = ext;
    alt_oe [pmx_pkg::PMX_BIT_LATCH] = ext;
    alt_out[pmx_pkg::PMX_BIT_LATCH] = bus_latch_n;
    alt_sel[pmx_pkg::PMX_BIT_READ]  = ext;
    alt_oe [pmx_pkg::PMX_BIT_READ]  = ext;
    alt_out[pmx_pkg::PMX_BIT_READ]  = bus_read_n;
    // one strobe serves both widths; the controller picks its bytes
    alt_sel[pmx_pkg::PMX_BIT_LSTB]  = ext && low_strobe_en;
    alt_oe [pmx_pkg::PMX_BIT_LSTB]  = ext && low_strobe_en;
    alt_out[pmx_pkg::PMX_BIT_LSTB]  = low_byte_store_strobe;
    alt_sel[pmx_pkg::PMX_BIT_HSTB]  = ext && bus_16bit && high_strobe_en;
    alt_oe [pmx_pkg::PMX_BIT_HSTB]  = ext && bus_16bit && high_strobe_en;
    alt_out[pmx_pkg::PMX_BIT_HSTB]  = high_byte_store_strobe;
    // request pin is input only while hold is on
    alt_sel[pmx_pkg::PMX_BIT_HREQ]  = ext && hold_en;
    alt_sel[pmx_pkg::PMX_BIT_HGNT]  = ext && hold_en;
    alt_oe [pmx_pkg::PMX_BIT_HGNT]  = ext && hold_en;
    alt_out[pmx_pkg::PMX_BIT_HGNT]  = bus_hold_grant;
    alt_sel[pmx_pkg::PMX_BIT_RDY]   = ext && ready_en;
    alt_sel[pmx_pkg::PMX_BIT_BCLK]  = ext && bclk_out_en;
    alt_oe [pmx_pkg::PMX_BIT_BCLK]  = ext && bclk_out_en;
    alt_out[pmx_pkg::PMX_BIT_BCLK]  = bus_clk;
  end

  // final pin drive: bus function, then compare wave, then gpio
  always_comb begin
    out_nxt = pdr_r;
    oe_nxt  = ddr_r;
    for (int i = 0; i < NPINS; i++) begin
      if (alt_sel[i]) begin
        out_nxt[i] = alt_out[i];  // gpio driver overridden
        oe_nxt[i]  = alt_oe[i];
      end else if (compare_en && i >= pmx_pkg::PMX_CMP_LO) begin
        // two-bit index: the guard keeps low pins away, the cast keeps it in range
        out_nxt[i] = compare_wave[2'(i - pmx_pkg::PMX_CMP_LO)];
        oe_nxt[i]  = 1'b1;
      end
    end
    // pull-up only applies while the pin is a gpio input
    pu_nxt = pucr_r & ~alt_sel & ~oe_nxt;
  end

  // registered pin outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port3_out    <= pmx_pkg::PMX_RST_ZERO;
      port3_oe     <= pmx_pkg::PMX_RST_ZERO;
      port3_pullup <= pmx_pkg::PMX_RST_ZERO;
    end else begin
      port3_out    <= out_nxt;
      port3_oe     <= oe_nxt;
      port3_pullup <= pu_nxt;
    end
  end

  // inputs back to the core; disabled functions see their idle level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_hold_request  <= 1'b0;
      bus_ready         <= pmx_pkg::PMX_RST_HI;
      capture_channel_4 <= 1'b0;
      capture_channel_5 <= 1'b0;
      ext_irq10_pin     <= 1'b0;
      ext_bus_mode      <= 1'b0;
      pin_data          <= pmx_pkg::PMX_RST_ZERO;
    end else begin
      bus_hold_request  <= alt_sel[pmx_pkg::PMX_BIT_HREQ] & pin_s[pmx_pkg::PMX_BIT_HREQ];
      // ready held high when off so accesses never stretch
      bus_ready         <= ~alt_sel[pmx_pkg::PMX_BIT_RDY] | pin_s[pmx_pkg::PMX_BIT_RDY];
      capture_channel_4 <= pin_s[pmx_pkg::PMX_BIT_LATCH];
      capture_channel_5 <= pin_s[pmx_pkg::PMX_BIT_READ];
      ext_irq10_pin     <= pin_s[pmx_pkg::PMX_BIT_LSTB];
      ext_bus_mode      <= ext;
      pin_data          <= pin_s;
    end
  end

  // checks: bus strobes on bits 0..3, each one edge behind its cause
  a_latch_own: assert property (@(posedge mclk) disable iff (!nrst)
    ext |=> port3_oe[0] && port3_out[0] == $past(bus_latch_n))
    else $error("latch strobe not on bit0");
  a_latch_gpio: assert property (@(posedge mclk) disable iff (!nrst)
    !ext |=> port3_oe[0] == $past(ddr_r[0]) && port3_out[0] == $past(pdr_r[0]))
    else $error("bit0 not gpio");
  a_read_own: assert property (@(posedge mclk) disable iff (!nrst)
    ext |=> port3_oe[1] && port3_out[1] == $past(bus_read_n))
    else $error("read strobe not on bit1");
  a_read_gpio: assert property (@(posedge mclk) disable iff (!nrst)
    !ext |=> port3_oe[1] == $past(ddr_r[1]) && port3_out[1] == $past(pdr_r[1]))
    else $error("bit1 not gpio");
  a_low_gpio: assert property (@(posedge mclk) disable iff (!nrst)
    (!ext || !low_strobe_en) |=> port3_oe[2] == $past(ddr_r[2]))
    else $error("bit2 not gpio");
  a_low_drive: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && low_strobe_en) |=> port3_oe[2] && port3_out[2] == $past(low_byte_store_strobe))
    else $error("low strobe missing");
  a_low_width: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && low_strobe_en && !bus_16bit) |=> port3_oe[2])
    else $error("byte strobe missing in 8-bit");
  a_high_gpio: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && !bus_16bit) |=> port3_oe[3] == $past(ddr_r[3]))
    else $error("bit3 not gpio in 8-bit");
  a_high_idle: assert property (@(posedge mclk) disable iff (!nrst)
    (!ext || !bus_16bit || !high_strobe_en) |=> port3_oe[3] == $past(ddr_r[3]))
    else $error("bit3 not gpio while strobe off");
  a_high_drive: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && bus_16bit && high_strobe_en) |=> port3_out[3] == $past(high_byte_store_strobe))
    else $error("high strobe missing");

  // checks: hold, ready and bus clock on bits 4..7
  a_hold_req: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && hold_en) |=> !port3_oe[4])
    else $error("hold request pin driven");
  a_hold_pass: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && hold_en) |=> bus_hold_request == $past(pin_s[4]))
    else $error("hold request not passed in");
  a_hold_gnt: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && hold_en) |=> port3_out[5] == $past(bus_hold_grant))
    else $error("hold grant missing");
  // two quiet cycles; the request flop already clears on the edge that samples hold off
  a_hold_off: assert property (@(posedge mclk) disable iff (!nrst)
    (!ext || !hold_en) ##1 (!ext || !hold_en) |=> !bus_hold_request)
    else $error("hold request leaked");
  a_grant_gpio: assert property (@(posedge mclk) disable iff (!nrst)
    ((!ext || !hold_en) && !compare_en) |=> port3_oe[5] == $past(ddr_r[5]))
    else $error("bit5 not gpio");
  a_ready_off: assert property (@(posedge mclk) disable iff (!nrst)
    (!ext || !ready_en) |=> bus_ready)
    else $error("ready stretched while off");
  a_ready_in: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && ready_en) |=> !port3_oe[6])
    else $error("ready pin driven");
  a_ready_pass: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && ready_en) |=> bus_ready == $past(pin_s[6]))
    else $error("ready not passed in");
  a_bclk_own: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && bclk_out_en) |=> port3_oe[7] && port3_out[7] == $past(bus_clk))
    else $error("bus clock missing");
  a_bclk_gpio: assert property (@(posedge mclk) disable iff (!nrst)
    ((!ext || !bclk_out_en) && !compare_en) |=> port3_oe[7] == $past(ddr_r[7]))
    else $error("bit7 not gpio");

  // checks: pull-ups and the timer routes
  a_pullup_gate: assert property (@(posedge mclk) disable iff (!nrst)
    port3_pullup[0] |-> !port3_oe[0] && !ext_bus_mode)
    else $error("pull-up on driven pin");
  a_pullup_load: assert property (@(posedge mclk) disable iff (!nrst)
    pucr_we |=> pucr_r == $past(pucr_wdata))
    else $error("pull-up selection not loaded");
  a_capture_path: assert property (@(posedge mclk) disable iff (!nrst)
    capture_channel_4 == $past(pin_s[0]))
    else $error("capture 4 path broken");
  a_capture_five: assert property (@(posedge mclk) disable iff (!nrst)
    capture_channel_5 == $past(pin_s[1]))
    else $error("capture 5 path broken");
  a_irq_path: assert property (@(posedge mclk) disable iff (!nrst)
    ext_irq10_pin == $past(pin_s[2]))
    else $error("irq10 path broken");
  a_compare_four: assert property (@(posedge mclk) disable iff (!nrst)
    (compare_en && !alt_sel[4]) |=> port3_oe[4] && port3_out[4] == $past(compare_wave[0]))
    else $error("compare wave 4 missing");
  a_compare_five: assert property (@(posedge mclk) disable iff (!nrst)
    (compare_en && !alt_sel[5]) |=> port3_oe[5] && port3_out[5] == $past(compare_wave[1]))
    else $error("compare wave 5 missing");
  a_compare_out: assert property (@(posedge mclk) disable iff (!nrst)
    (compare_en && !alt_sel[6]) |=> port3_oe[6] && port3_out[6] == $past(compare_wave[2]))
    else $error("compare wave 6 missing");
  a_compare_seven: assert property (@(posedge mclk) disable iff (!nrst)
    (compare_en && !alt_sel[7]) |=> port3_oe[7] && port3_out[7] == $past(compare_wave[3]))
    else $error("compare wave 7 missing");
  a_bus_prio: assert property (@(posedge mclk) disable iff (!nrst)
    (ext && hold_en && compare_en) |=> port3_out[5] == $past(bus_hold_grant))
    else $error("bus lost to compare");
endmodule // pmx_port3

// *** hdl/pmx_sync.sv ***
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pmx_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // first stage, metastability catcher

  // two stages; reset to zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pmx_sync

// *** testbench/pmx_bus_dev.sv ***
// Purpose: far-side board model for the eight port-3 pins
// Assumes: the board drives only pins that the device leaves undriven
// Notes:   floating pins toggle every cycle so a stale level is never read
`timescale 1ns/1ps
module pmx_bus_dev (
  // clock
  input  wire logic       mclk,
  // device pin side
  input  wire logic [7:0] port3_out,
  input  wire logic [7:0] port3_oe,
  input  wire logic [7:0] port3_pullup,
  // board drive: hold request on bit 4, ready on bit 6, plain levels elsewhere
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] ext_val,
  // resolved wire levels
  output logic      [7:0] port3_in
);
  logic [7:0] float_r = 8'h55;  // level seen on a pin nobody drives

  // free pattern, flips each cycle so an undriven pin never holds a value
  always @(posedge mclk) float_r <= ~float_r;

  // wire level: device first, then board, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port3_oe[i]) port3_in[i] = port3_out[i];
      else if (ext_drive[i]) port3_in[i] = ext_val[i];
      else if (port3_pullup[i]) port3_in[i] = 1'h1;
      else port3_in[i] = float_r[i];
    end
  end
endmodule // pmx_bus_dev

// *** testbench/pmx_port3_test.sv ***
// Purpose: self-checking bench for the port-3 pin function selector
// Assumes: all outputs settle within twelve cycles of a config change
// Notes:   released pins with a pull-up are left to it; the board drives the rest
`timescale 1ns/1ps
module pmx_port3_test;
  typedef struct packed {
    logic [7:0] out, oe, pu, mout, pins;
    logic [4:0] side;  // hold request, ready, capture 4, capture 5, irq10
    logic       ext;
  } pmx_note_t;
  logic       mclk = 1'h0;
  logic       nrst = 1'h0;
  logic [2:0] mode_code = 3'h3;  // straps, single-chip at start
  logic [6:0] cfg = 7'h00;       // 16bit, low, high strobe, hold, ready, bclk, compare
  logic [5:0] ctl = 6'h00;       // latch, read, wrl, wrh, grant, bus clock
  logic [3:0] cw = 4'h0;         // compare waves 4..7
  logic [2:0] we = 3'h0;         // pdr, ddr, pucr write strobes
  logic [7:0] pdr = 8'h00, ddr = 8'h00, pucr = 8'h00;
  logic [7:0] ext_drive = 8'hFF, ext_val = 8'h00;
  logic [7:0] p_in, p_out, p_oe, p_pu, pin_data;
  logic       hreq, rdy, cap4, cap5, irq10, ext_mode;
  logic [31:0] seed = 32'h1FD0C9F0;
  pmx_note_t  notes[$];
  pmx_note_t  cur, n;
  int         n_mismatch = 0;
  int         n_compared = 0;

  always #20 mclk = ~mclk;

  pmx_port3 i_dut (.mclk(mclk), .nrst(nrst),
    .mode_select_0(mode_code[0]), .mode_select_1(mode_code[1]),
    .mode_select_2(mode_code[2]), .bus_16bit(cfg[0]), .low_strobe_en(cfg[1]),
    .high_strobe_en(cfg[2]), .hold_en(cfg[3]), .ready_en(cfg[4]), .bclk_out_en(cfg[5]),
    .compare_en(cfg[6]), .pdr_we(we[0]), .pdr_wdata(pdr), .ddr_we(we[1]),
    .ddr_wdata(ddr), .pucr_we(we[2]), .pucr_wdata(pucr), .bus_latch_n(ctl[0]),
    .bus_read_n(ctl[1]), .low_byte_store_strobe(ctl[2]),
    .high_byte_store_strobe(ctl[3]), .bus_hold_grant(ctl[4]), .bus_clk(ctl[5]),
    .bus_hold_request(hreq), .bus_ready(rdy), .compare_wave(cw),
    .capture_channel_4(cap4), .capture_channel_5(cap5), .ext_irq10_pin(irq10),
    .ext_bus_mode(ext_mode), .pin_data(pin_data), .port3_in(p_in),
    .port3_out(p_out), .port3_oe(p_oe), .port3_pullup(p_pu));

  pmx_bus_dev i_board (.mclk(mclk), .port3_out(p_out), .port3_oe(p_oe),
    .port3_pullup(p_pu), .ext_drive(ext_drive), .ext_val(ext_val), .port3_in(p_in));

  // random source for all stimulus but the mode code
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected pin picture from mode, enables and port registers
  function automatic pmx_note_t expect_of();
    pmx_note_t  r;
    logic       e;
    logic [7:0] own, obus, gp_o, gp_e;
    e    = (mode_code <= 3'h2);  // codes 0..2 run the external bus
    own  = {e & cfg[5], e & cfg[4], e & cfg[3], e & cfg[3],
            e & cfg[0] & cfg[2], e & cfg[1], e, e};
    obus = own & 8'hAF;          // bits 4 and 6 are bus inputs
    gp_o = cfg[6] ? {cw, pdr[3:0]} : pdr;
    gp_e = cfg[6] ? {4'hF, ddr[3:0]} : ddr;
    r.oe   = obus | (~own & gp_e);
    r.out  = (own & {ctl[5], 1'h0, ctl[4], 1'h0, ctl[3:0]}) | (~own & gp_o);
    r.mout = r.oe;
    r.pu   = ~own & ~r.oe & pucr;
    r.pins = (r.oe & r.out) | r.pu | (~r.oe & ~r.pu & ext_val);
    r.side = {e & cfg[3] & r.pins[4], ~(e & cfg[4]) | r.pins[6],
              r.pins[0], r.pins[1], r.pins[2]};
    r.ext  = e;
    return r;
  endfunction

  // single comparison point, counts every compare
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // monitor: outputs are settled at the falling edge, oldest note first
  always @(negedge mclk) begin
    if (notes.size() > 0) begin
      cur = notes.pop_front();
      check(p_oe, cur.oe);
      check(p_out & cur.mout, cur.out & cur.mout);
      check(p_out, cur.out);
      check(p_pu, cur.pu);
      check(pin_data, cur.pins);
      check({3'h0, hreq, rdy, cap4, cap5, irq10}, {3'h0, cur.side});
      check({7'h00, ext_mode}, {7'h00, cur.ext});
    end
  end

  // main sequence: reset picture, then every mode code with random setup
  initial begin
    repeat (3) @(posedge mclk);
    notes.push_back('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 5'h08, 1'h0});
    repeat (3) @(posedge mclk);
    nrst <= 1'h1;
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      seed = lfsr(seed);
      mode_code <= i[2:0];
      cfg <= seed[6:0];
      ctl <= seed[12:7];
      cw  <= seed[16:13];
      seed = lfsr(lfsr(seed));
      {ext_val, pucr, ddr, pdr} <= seed;
      we <= 3'h7;
      @(posedge mclk);
      we <= 3'h0;
      n = expect_of();
      ext_drive <= ~(n.oe | n.pu);  // pulled-up pins are left to the pull-up
      repeat (12) @(posedge mclk);
      notes.push_back(n);
    end
    @(posedge mclk);
    report_and_stop();
  end

  // watchdog sized from 64 steps at 16 cycles (each takes 14) plus 100 for reset
  initial begin
    repeat (64 * 16 + 100) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // pmx_port3_test
